// *** shared/ccu_regs.svh ***
// Purpose: Register offsets, field positions, reset values of the capture/compare unit
// Assumes: Word index addressing on a plain register port
// Notes:   Definitions only
`ifndef CCU_REGS_SVH
`define CCU_REGS_SVH
// ==========================================================
// Register indices
`define CCU_IDX_CTRL      4'h0
`define CCU_IDX_COUNT     4'h1
`define CCU_IDX_MODULO    4'h2
`define CCU_IDX_SC_BASE   4'h3
`define CCU_IDX_VAL_BASE  4'h7
`define CCU_IDX_LAST      4'hA
// ==========================================================
// Counter status/control fields
`define CCU_CTRL_OVF_FLAG 7
`define CCU_CTRL_OVF_IE   6
`define CCU_CTRL_STOP     5
`define CCU_CTRL_RESET    4
// ==========================================================
// Channel status/control fields
`define CCU_SC_FLAG       7
`define CCU_SC_IE         6
`define CCU_SC_BUF_SEL    5
`define CCU_SC_MODE_A     4
`define CCU_SC_EDGE_HI    3
`define CCU_SC_EDGE_LO    2
`define CCU_SC_OVF_TGL    1
// ==========================================================
// Reset values and constants
`define CCU_RST_MODULO    16'hFFFF
`define CCU_RST_STOP      1'b1
`define CCU_PS_EXTERNAL   3'h7
`endif

// *** shared/ccu_pkg.sv ***
// Purpose: Types of the capture/compare unit
// Assumes: Constants come from ccu_regs.svh
// Notes:   State is one packed struct
package ccu_pkg;
  // ==========================================================
  // Edge/level select field decode
  typedef enum logic [1:0] {
    CCU_EL_OFF,
    CCU_EL_RISE_TGL,
    CCU_EL_FALL_CLR,
    CCU_EL_BOTH_SET
  } ccu_edge_t;

  // ==========================================================
  // Whole state of the unit
  typedef struct packed {
    logic [15:0]       cnt;
    logic [15:0]       modv;
    logic [6:0]        pre;
    logic [2:0]        ps;
    logic              stop;
    logic              ovf_flag;
    logic              ovf_ie;
    logic [3:0][7:0]   sc;
    logic [3:0][15:0]  val;
    logic [3:0]        pin_out;
    logic [3:0]        pin_oe;
    logic [3:0]        pin_prev;
    logic              ext_prev;
    logic [1:0]        act;
    logic [1:0]        pend;
    logic [1:0]        psel;
    logic [15:0]       rdata;
    logic              irq;
  } ccu_state_t;
endpackage : ccu_pkg

// *** rtl/ccu_timer.sv ***
// Purpose: Four-channel capture/compare timer on a 16-bit up-counter
// Assumes: Inputs synchronous to clock_i; read data valid the cycle after rd_i
// Notes:   Pins are split into input, output and output enable
`timescale 1ns/1ns
`default_nettype none
`include "ccu_regs.svh"

// ==========================================================
module ccu_timer (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [15:0] rdata_o,
  input  wire logic [3:0]  ch_pin_i,
  output var  logic [3:0]  ch_pin_o,
  output var  logic [3:0]  ch_pin_oe_o,
  input  wire logic        external_count_clock_i,
  output var  logic        irq_o
);
  import ccu_pkg::*;

  ccu_state_t  r;
  ccu_state_t  n;
  logic        tick;
  logic        ovf;
  logic [3:0]  cap_ev;
  logic [3:0]  cmp_ev;

  // ==========================================================
  // Helpers
  // Prescaler tap: rate select s gives one tick per 2**s bus clocks
  function automatic logic presc_hit(input logic [6:0] pre, input logic [2:0] s);
    logic [6:0] mask;
    mask = 7'h7F >> (3'h7 - s);
    if (s == 3'h0) begin
      mask = 7'h00;
    end
    presc_hit = ((pre & mask) == mask);
  endfunction : presc_hit

  // Channel is in compare mode; buffer select outranks mode A
  function automatic logic is_compare(input logic [7:0] sc, input logic even);
    is_compare = (even && sc[`CCU_SC_BUF_SEL]) || sc[`CCU_SC_MODE_A];
  endfunction : is_compare

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] cmpv;
    logic        linked_up;
    logic        linked_lo;
    logic        rise;
    logic        fall;
    logic [3:0]  idx;
    ccu_edge_t   el;
    cmpv      = 16'h0000;
    linked_up = 1'b0;
    linked_lo = 1'b0;
    rise      = 1'b0;
    fall      = 1'b0;
    idx       = 4'h0;
    el        = CCU_EL_OFF;
    n         = r;
    cap_ev    = 4'h0;
    cmp_ev    = 4'h0;
    n.rdata   = 16'h0000;
    n.pin_prev = ch_pin_i;
    n.ext_prev = external_count_clock_i;
    // Count clock from the prescaler or the external pin's rising edge
    if (r.ps == `CCU_PS_EXTERNAL) begin
      tick = !r.stop && external_count_clock_i && !r.ext_prev;
    end else begin
      tick = !r.stop && presc_hit(r.pre, r.ps);
    end
    ovf   = tick && (r.cnt == r.modv || r.cnt == 16'hFFFF);
    n.pre = r.pre + 7'h01;
    if (tick) begin
      n.cnt = ovf ? 16'h0000 : r.cnt + 16'h0001;
    end
    // Software writes come first so that hardware events win over clears
    if (wr_i) begin
      if (addr_i == `CCU_IDX_CTRL) begin
        n.ps       = wdata_i[2:0];
        n.stop     = wdata_i[`CCU_CTRL_STOP];
        n.ovf_ie   = wdata_i[`CCU_CTRL_OVF_IE];
        n.ovf_flag = r.ovf_flag & wdata_i[`CCU_CTRL_OVF_FLAG];
        if (wdata_i[`CCU_CTRL_RESET]) begin
          n.cnt = 16'h0000;
          n.pre = 7'h00;
        end
      end else if (addr_i == `CCU_IDX_MODULO) begin
        n.modv = wdata_i;
      end else if (addr_i >= `CCU_IDX_SC_BASE && addr_i < `CCU_IDX_VAL_BASE) begin
        idx = addr_i - `CCU_IDX_SC_BASE;
        n.sc[idx[1:0]] = {r.sc[idx[1:0]][`CCU_SC_FLAG] & wdata_i[`CCU_SC_FLAG], wdata_i[6:1], 1'b0};
      end else if (addr_i >= `CCU_IDX_VAL_BASE && addr_i <= `CCU_IDX_LAST) begin
        idx = addr_i - `CCU_IDX_VAL_BASE;
        n.val[idx[1:0]] = wdata_i;
      end
    end
    if (ovf) begin
      n.ovf_flag = 1'b1;
    end
    // Buffered pairs: switch the governing channel only at overflow
    for (int p = 0; p < 2; p++) begin
      if (!r.sc[2*p][`CCU_SC_BUF_SEL]) begin
        n.act[p]  = 1'b0;
        n.pend[p] = 1'b0;
      end else begin
        if (ovf && r.pend[p]) begin
          n.act[p]  = r.psel[p];
          n.pend[p] = 1'b0;
        end
        if (wr_i && addr_i >= `CCU_IDX_VAL_BASE && addr_i <= `CCU_IDX_LAST) begin
          idx = addr_i - `CCU_IDX_VAL_BASE;
          if (idx[1] == p[0]) begin
            n.pend[p] = 1'b1;
            n.psel[p] = idx[0];
          end
        end
      end
    end
    // Per-channel capture and compare
    for (int i = 0; i < 4; i++) begin
      linked_up = (i % 2 == 1) && r.sc[i-(i%2)][`CCU_SC_BUF_SEL];
      linked_lo = (i % 2 == 0) && r.sc[i][`CCU_SC_BUF_SEL];
      el        = ccu_edge_t'(r.sc[i][`CCU_SC_EDGE_HI:`CCU_SC_EDGE_LO]);
      cmpv      = (linked_lo && r.act[i/2]) ? r.val[i|1] : r.val[i];
      rise      = ch_pin_i[i] && !r.pin_prev[i];
      fall      = !ch_pin_i[i] && r.pin_prev[i];
      if (linked_up) begin
        n.pin_oe[i] = 1'b0;
      end else if (is_compare(r.sc[i], (i % 2 == 0))) begin
        n.pin_oe[i] = (el != CCU_EL_OFF);
        if (tick && r.cnt == cmpv) begin
          cmp_ev[i] = 1'b1;
          n.sc[i][`CCU_SC_FLAG] = 1'b1;
          unique case (el)
            CCU_EL_OFF:      n.pin_out[i] = r.pin_out[i];
            CCU_EL_RISE_TGL: n.pin_out[i] = !r.pin_out[i];
            CCU_EL_FALL_CLR: n.pin_out[i] = 1'b0;
            CCU_EL_BOTH_SET: n.pin_out[i] = 1'b1;
          endcase
        end else if (ovf && r.sc[i][`CCU_SC_OVF_TGL]) begin
          n.pin_out[i] = !r.pin_out[i];
        end
      end else begin
        n.pin_oe[i] = 1'b0;
        unique case (el)
          CCU_EL_OFF:      cap_ev[i] = 1'b0;
          CCU_EL_RISE_TGL: cap_ev[i] = rise;
          CCU_EL_FALL_CLR: cap_ev[i] = fall;
          CCU_EL_BOTH_SET: cap_ev[i] = rise || fall;
        endcase
        if (cap_ev[i]) begin
          n.val[i] = r.cnt;
          n.sc[i][`CCU_SC_FLAG] = 1'b1;
        end
      end
    end
    // Interrupt request from enabled flags; freed upper channels stay quiet
    n.irq = r.ovf_flag && r.ovf_ie;
    for (int i = 0; i < 4; i++) begin
      if (!((i % 2 == 1) && r.sc[i-(i%2)][`CCU_SC_BUF_SEL])) begin
        n.irq = n.irq || (r.sc[i][`CCU_SC_FLAG] && r.sc[i][`CCU_SC_IE]);
      end
    end
    // Read data for next cycle; reading has no side effect on the count
    if (rd_i) begin
      if (addr_i == `CCU_IDX_CTRL) begin
        n.rdata = {8'h00, r.ovf_flag, r.ovf_ie, r.stop, 2'b00, r.ps};
      end else if (addr_i == `CCU_IDX_COUNT) begin
        n.rdata = r.cnt;
      end else if (addr_i == `CCU_IDX_MODULO) begin
        n.rdata = r.modv;
      end else if (addr_i >= `CCU_IDX_SC_BASE && addr_i < `CCU_IDX_VAL_BASE) begin
        idx = addr_i - `CCU_IDX_SC_BASE;
        n.rdata = {8'h00, r.sc[idx[1:0]]};
      end else if (addr_i >= `CCU_IDX_VAL_BASE && addr_i <= `CCU_IDX_LAST) begin
        idx = addr_i - `CCU_IDX_VAL_BASE;
        n.rdata = r.val[idx[1:0]];
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r      <= '0;
      r.modv <= `CCU_RST_MODULO;
      r.stop <= `CCU_RST_STOP;
    end else begin
      r <= n;
    end
  end

  assign rdata_o     = r.rdata;
  assign ch_pin_o    = r.pin_out;
  assign ch_pin_oe_o = r.pin_oe;
  assign irq_o       = r.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_cnt_wraps_zero: assert property (ovf && !wr_i |=> r.cnt == 16'h0000 && r.ovf_flag)
    else $error("counter did not wrap on overflow");
  a_cnt_steps_one: assert property (tick && !ovf && !wr_i |=> r.cnt == $past(r.cnt) + 16'h0001)
    else $error("counter did not step by one");
  a_stop_holds_cnt: assert property (r.stop && !wr_i |=> r.cnt == $past(r.cnt))
    else $error("counter moved while stopped");
  a_read_no_disturb: assert property (rd_i && addr_i == `CCU_IDX_COUNT && !tick |=> r.cnt == $past(r.cnt)
    ##0 rdata_o == $past(r.cnt))
    else $error("count read disturbed counting or returned wrong value");
  a_capture_latches: assert property (cap_ev[2] |=> r.val[2] == $past(r.cnt)
    && r.sc[2][`CCU_SC_FLAG])
    else $error("capture did not latch the counter");
  a_compare_sets_pin: assert property (cmp_ev[1] && r.sc[1][`CCU_SC_EDGE_HI:`CCU_SC_EDGE_LO] == 2'b11
    |=> ch_pin_o[1] && r.sc[1][`CCU_SC_FLAG])
    else $error("compare set action missed");
  a_upper_pin_freed: assert property (r.sc[0][`CCU_SC_BUF_SEL] |=> !ch_pin_oe_o[1])
    else $error("linked upper pin still driven");
  a_buffer_switch: assert property (ovf && r.pend[0] && r.sc[0][`CCU_SC_BUF_SEL]
    |=> r.act[0] == $past(r.psel[0]))
    else $error("pair did not switch at overflow");
  a_switch_only_ovf: assert property (!ovf && r.sc[2][`CCU_SC_BUF_SEL] && $stable(r.sc[2])
    |=> $stable(r.act[1]))
    else $error("pair switched away from overflow");
  a_irq_follows: assert property (r.ovf_flag && r.ovf_ie |=> irq_o)
    else $error("overflow request not raised");
endmodule : ccu_timer
`default_nettype wire

// *** verification/ccu_pin_env.sv ***
// Purpose: Far side of the four channel pins
// Assumes: No pull on the pins
// Notes:   The bench chooses the event level
`timescale 1ns/1ns
`default_nettype none
// ====================
// Pin wire level
module ccu_pin_env (
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] pin_o_i,
  input  wire logic [3:0] pin_oe_i,
  output var  logic [3:0] lvl_o
);
  // Unit wins where it drives, else the event source shows
  always_comb lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_i);
endmodule : ccu_pin_env
`default_nettype wire

// *** verification/four_channel_capture_compare_timer_tb.sv ***
// Purpose: Self-checking bench of the capture/compare unit
// Assumes: Rate select 0 ticks every cycle
// Notes:   Prescaler phase is unknown, so rates allow one count slack
`timescale 1ns/1ns
`default_nettype none
`include "ccu_regs.svh"
module four_channel_capture_compare_timer_tb;
  import ccu_pkg::*;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ext = 1'b0, irq;
  logic [3:0]  addr_i = 4'h0, drv = 4'h0, lvl, p_o, p_oe;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, tg = 0;
  ccu_timer i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ch_pin_i(lvl), .ch_pin_o(p_o),
    .ch_pin_oe_o(p_oe), .external_count_clock_i(ext), .irq_o(irq));
  ccu_pin_env i_env (.drv_i(drv), .pin_o_i(p_o), .pin_oe_i(p_oe), .lvl_o(lvl));
  // ====================
  // Clock, hang guard, toggle counter
  initial forever #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  always @(p_o[1]) tg++;
  // ====================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic cw(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cw
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data are only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask : rd
  // A 100-cycle window equals one period, so phase does not matter
  task automatic hi_cnt(input int ch, input logic [15:0] e);
    int h;
    h = 0;
    repeat (100) begin
      @(negedge clock_i);
      h += int'(p_o[ch] === 1'b1);
    end
    chk(h + 1 >= e && h <= e + 1, "pulse width");
  endtask : hi_cnt
  // Handler stand-in: the request must come within one period and a half
  task automatic wait_irq(input string m);
    int k;
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while (irq !== 1'b1 && k < 150);
    chk(k < 150, m);
  endtask : wait_irq
  // ====================
  // Main sequence
  initial begin
    logic [15:0] v, c0;
    int n, a;
    void'($urandom(24961));
    cw(12);
    rst_n_i <= 1'b1;
    rd(`CCU_IDX_CTRL, v);
    chk(v === 16'h0020, "ctrl reset");
    rd(`CCU_IDX_MODULO, v);
    chk(v === 16'hFFFF, "modulo reset");
    rd(4'hB, v);
    chk(v === 16'h0000, "unmapped");
    // Seven internal rates, then the external clock
    for (int s = 0; s < 7; s++) begin
      wr(`CCU_IDX_CTRL, 16'h0010 | {13'h0000, 3'(s)});
      cw(8 << s);
      wr(`CCU_IDX_CTRL, 16'h0020 | {13'h0000, 3'(s)});
      rd(`CCU_IDX_COUNT, v);
      n = ((8 << s) + 2) >> s;
      chk(v + 1 >= n && v <= n + 1, "rate");
    end
    wr(`CCU_IDX_CTRL, 16'h0017);
    repeat (5) begin
      cw(3);
      ext <= 1'b1;
      cw(3);
      ext <= 1'b0;
    end
    cw(3);
    wr(`CCU_IDX_CTRL, 16'h0027);
    rd(`CCU_IDX_COUNT, v);
    chk(v === 16'h0005, "external count");
    $display("rates done");
    // Modulo wrap, overflow flag, reads never disturb counting
    wr(`CCU_IDX_MODULO, 16'h0014);
    wr(`CCU_IDX_CTRL, 16'h0010);
    rd(`CCU_IDX_COUNT, v);
    rd(`CCU_IDX_COUNT, c0);
    chk(c0 === v + 16'h0002, "count step");
    rd(`CCU_IDX_CTRL, v);
    chk(v[7] === 1'b0, "early flag");
    cw(20);
    rd(`CCU_IDX_CTRL, v);
    chk(v[7] === 1'b1, "overflow flag");
    repeat (8) begin
      cw($urandom_range(1, 9));
      rd(`CCU_IDX_COUNT, v);
      chk(v <= 16'h0014, "modulo bound");
    end
    $display("counter done");
    // Compare actions on channel 1
    wr(`CCU_IDX_MODULO, 16'h0063);
    wr(`CCU_IDX_VAL_BASE + 4'h1, 16'($urandom_range(10, 80)));
    for (int m = 0; m < 2; m++) begin
      wr(`CCU_IDX_SC_BASE + 4'h1, m ? 16'h0018 : 16'h001C);
      cw(110);
      chk(p_o[1] === (m == 0) && p_oe[1] === 1'b1, "set or clear");
      tg = 0;
      cw(200);
      chk(tg == 0, "no repeat change");
    end
    wr(`CCU_IDX_SC_BASE + 4'h1, 16'h0014);
    tg = 0;
    cw(400);
    chk(tg >= 3 && tg <= 5, "toggle");
    // Linked pairs: idle channel takes over after overflow
    for (int p = 0; p < 4; p += 2) begin
      v = 16'($urandom_range(10, 80));
      c0 = 16'($urandom_range(10, 80));
      wr(`CCU_IDX_VAL_BASE + 4'(p), v);
      wr(`CCU_IDX_SC_BASE + 4'(p), 16'h003A);
      cw(150);
      hi_cnt(p, v);
      chk(p_oe[p + 1] === 1'b0, "upper pin freed");
      wr(`CCU_IDX_VAL_BASE + 4'(p + 1), c0);
      cw(150);
      hi_cnt(p, c0);
      wr(`CCU_IDX_VAL_BASE + 4'(p), v);
      cw(150);
      hi_cnt(p, v);
    end
    wr(`CCU_IDX_SC_BASE + 4'h2, 16'h001A);
    wr(`CCU_IDX_VAL_BASE + 4'h2, 16'h0020);
    cw(150);
    hi_cnt(2, 16'h0020);
    // Synchronised rewrites give no wrong period: lower after compare, raise after overflow
    v = 16'($urandom_range(10, 30));
    c0 = 16'($urandom_range(40, 80));
    wr(`CCU_IDX_SC_BASE + 4'h2, 16'h005A);
    wait_irq("compare request");
    wr(`CCU_IDX_VAL_BASE + 4'h2, v);
    wr(`CCU_IDX_SC_BASE + 4'h2, 16'h001A);
    hi_cnt(2, v);
    wr(`CCU_IDX_CTRL, 16'h0040);
    wait_irq("overflow request");
    wr(`CCU_IDX_VAL_BASE + 4'h2, c0);
    wr(`CCU_IDX_CTRL, 16'h0000);
    hi_cnt(2, c0);
    $display("compare done");
    // Capture on channel 2 with the counter frozen
    wr(`CCU_IDX_CTRL, 16'h0010);
    cw($urandom_range(50, 500));
    wr(`CCU_IDX_CTRL, 16'h0020);
    rd(`CCU_IDX_COUNT, c0);
    for (int e = 0; e < 4; e++) begin
      for (int f = 0; f < 2; f++) begin
        @(posedge clock_i);
        drv[2] <= f[0];
        cw(2);
        wr(`CCU_IDX_SC_BASE + 4'h2, 16'h0040 | 16'(e << 2));
        wr(`CCU_IDX_VAL_BASE + 4'h2, 16'h0000);
        drv[2] <= ~f[0];
        cw(3);
        a = (e >> f) & 1;
        rd(`CCU_IDX_SC_BASE + 4'h2, v);
        chk(v[7] === a[0] && irq === a[0], "capture flag");
        rd(`CCU_IDX_VAL_BASE + 4'h2, v);
        chk(v === (a[0] ? c0 : 16'h0000), "capture value");
      end
    end
    $display("capture done");
    stop_test();
  end
endmodule : four_channel_capture_compare_timer_tb
`default_nettype wire
